/* File: rtl/uefc_defs.svh */
`ifndef UEFC_DEFS_SVH
`define UEFC_DEFS_SVH
`define UEFC_OFF_CTRL 8'h00
`define UEFC_OFF_EP_EN 8'h04
`define UEFC_OFF_IN_BUSY 8'h08
`define UEFC_OFF_OUT_BUSY 8'h0c
`define UEFC_OFF_TOGGLE 8'h10
`define UEFC_OFF_IRQ_STAT 8'h14
`define UEFC_OFF_IRQ_CLR 8'h18
`define UEFC_OFF_IRQ_EN 8'h1c
`define UEFC_OFF_FIFO_ADDR 8'h20
`define UEFC_OFF_FIFO_DATA 8'h24
`define UEFC_OFF_PAIR 8'h28
`define UEFC_NUM_EP 10
`define UEFC_FIFO_DEPTH 64
`define UEFC_CTRL_PRESCALE_LSB 0
`define UEFC_CTRL_PRESCALE_W 3
`define UEFC_PRESCALE_UNDIV 3'h0
`define UEFC_IRQ_BUS_RESET 0
`define UEFC_IRQ_IN_LSB 1
`define UEFC_IRQ_OUT_LSB 11
`define UEFC_IRQ_W 21
`define UEFC_RESP_OKAY 2'h0
`define UEFC_RESP_SLVERR 2'h2
`endif

/* File: rtl/uefc_pkg.sv */
`default_nettype none
package uefc_pkg;
  typedef logic [9:0] uefc_ep_t;
  typedef logic [31:0] uefc_word_t;
  typedef logic [7:0] uefc_addr_t;
  typedef enum logic [1:0] {UEFC_RD_IDLE, UEFC_RD_RESP} uefc_rd_e;
endpackage
`default_nettype wire

/* File: rtl/uefc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uefc_defs.svh"
module uefc_top
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_bus_reset,
  input wire logic [9:0] usb_in_sent,
  input wire logic [9:0] usb_out_rcvd,
  input wire logic mcu_idle,
  input wire logic dbg_access,
  output logic [2:0] mcu_clock_prescale_field,
  output logic [9:0] in_fifo_busy,
  output logic [9:0] out_fifo_busy,
  output logic [9:0] in_toggle,
  output logic usb_irq,
  output logic mcu_wake
);
  import uefc_pkg::*;

  // usb events are asynchronous to clk: two stages before use
  logic [20:0] ev_s1_reg, ev_s2_reg, ev_s3_reg;
  logic dbg_s1_reg, dbg_s2_reg, idle_s1_reg, idle_s2_reg;
  logic [20:0] ev_pulse;
  logic [2:0] prescale_reg;
  uefc_ep_t ep_en_reg, in_busy_reg, out_busy_reg, toggle_reg, pair_reg;
  logic [20:0] stat_reg, irq_en_reg;
  logic [5:0] fifo_addr_reg;
  logic [3:0] fifo_ep_reg;
  logic [7:0] fifo_mem [0:(`UEFC_NUM_EP*`UEFC_FIFO_DEPTH)-1];
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wr_fire, rd_fire;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  uefc_rd_e rd_state_reg;

  function automatic logic [9:0] fifo_index(input logic [3:0] ep,
                                             input logic [5:0] a);
    fifo_index = 10'(ep * 7'd64 + {4'h0, a});
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_s1_reg <= '0;
      ev_s2_reg <= '0;
      ev_s3_reg <= '0;
      dbg_s1_reg <= 1'b0;
      dbg_s2_reg <= 1'b0;
      idle_s1_reg <= 1'b0;
      idle_s2_reg <= 1'b0;
    end else begin
      ev_s1_reg <= {usb_out_rcvd, usb_in_sent, usb_bus_reset};
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
      dbg_s1_reg <= dbg_access;
      dbg_s2_reg <= dbg_s1_reg;
      idle_s1_reg <= mcu_idle;
      idle_s2_reg <= idle_s1_reg;
    end
  end

  // bus-reset edge detection uses clk, independent of the prescale
  assign ev_pulse = ev_s2_reg & ~ev_s3_reg;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UEFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg > `UEFC_OFF_PAIR || awaddr_reg[1:0] != 2'h0 ||
            awaddr_reg == `UEFC_OFF_TOGGLE ||
            awaddr_reg == `UEFC_OFF_IRQ_STAT)
          s_axi_bresp <= `UEFC_RESP_SLVERR;
        else
          s_axi_bresp <= `UEFC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; only reset_n clears them, never a usb bus reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_reg <= `UEFC_PRESCALE_UNDIV;
      ep_en_reg <= '0;
      irq_en_reg <= '0;
      pair_reg <= '0;
      fifo_addr_reg <= '0;
      fifo_ep_reg <= '0;
    end else if (wr_fire) begin
      if (awaddr_reg == `UEFC_OFF_CTRL) begin
        prescale_reg <= wdata_reg[`UEFC_CTRL_PRESCALE_LSB +: 3];
      end else if (awaddr_reg == `UEFC_OFF_EP_EN) begin
        ep_en_reg <= wdata_reg[9:0];
      end else if (awaddr_reg == `UEFC_OFF_IRQ_EN) begin
        irq_en_reg <= wdata_reg[20:0];
      end else if (awaddr_reg == `UEFC_OFF_PAIR) begin
        pair_reg <= wdata_reg[9:0];
      end else if (awaddr_reg == `UEFC_OFF_FIFO_ADDR) begin
        fifo_addr_reg <= wdata_reg[5:0];
        fifo_ep_reg <= wdata_reg[11:8];
      end else if (awaddr_reg == `UEFC_OFF_FIFO_DATA) begin
        fifo_addr_reg <= 6'(fifo_addr_reg + 6'h1);
      end
    end else if (rd_fire && s_axi_araddr == `UEFC_OFF_FIFO_DATA) begin
      fifo_addr_reg <= 6'(fifo_addr_reg + 6'h1);
    end
  end

  // fifo storage: written only by bus writes, debugger access ignored
  always_ff @(posedge clk) begin
    if (wr_fire && awaddr_reg == `UEFC_OFF_FIFO_DATA && !dbg_s2_reg &&
        fifo_ep_reg < 4'd10 && wdata_reg[31] == 1'b0)
      fifo_mem[fifo_index(fifo_ep_reg, fifo_addr_reg)] <= wdata_reg[7:0];
  end

  // busy bits: in busy set by firmware arming, out busy also set by a receive; never cleared by the engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_busy_reg <= '0;
      out_busy_reg <= '0;
    end else begin
      if (wr_fire && awaddr_reg == `UEFC_OFF_IN_BUSY)
        in_busy_reg <= wdata_reg[9:0];
      // a receive in the cycle of a firmware clear still sets busy
      out_busy_reg <= (wr_fire && awaddr_reg == `UEFC_OFF_OUT_BUSY ?
                       wdata_reg[9:0] : out_busy_reg) |
                      (ev_pulse[20:11] & ep_en_reg);
    end
  end

  // toggle advances per packet sent; cleared when endpoint disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_reg <= '0;
    end else begin
      toggle_reg <= (toggle_reg ^ (ev_pulse[10:1] & ep_en_reg)) &
                    ep_en_reg;
    end
  end

  // sticky status: set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~((wr_fire &&
                  awaddr_reg == `UEFC_OFF_IRQ_CLR) ? wdata_reg[20:0] :
                  21'h0)) | ev_pulse;
    end
  end

  assign usb_irq = |(stat_reg & irq_en_reg);
  // wake is combinational so an idle core needs no clock edge
  assign mcu_wake = usb_irq & idle_s2_reg;

  always_comb begin
    rdata_next = 32'h0;
    rresp_next = `UEFC_RESP_OKAY;
    if (s_axi_araddr == `UEFC_OFF_CTRL) begin
      rdata_next = {29'h0, prescale_reg};
    end else if (s_axi_araddr == `UEFC_OFF_EP_EN) begin
      rdata_next = {22'h0, ep_en_reg};
    end else if (s_axi_araddr == `UEFC_OFF_IN_BUSY) begin
      rdata_next = {22'h0, in_busy_reg};
    end else if (s_axi_araddr == `UEFC_OFF_OUT_BUSY) begin
      rdata_next = {22'h0, out_busy_reg};
    end else if (s_axi_araddr == `UEFC_OFF_TOGGLE) begin
      rdata_next = {22'h0, toggle_reg};
    end else if (s_axi_araddr == `UEFC_OFF_IRQ_STAT) begin
      rdata_next = {11'h0, stat_reg};
    end else if (s_axi_araddr == `UEFC_OFF_IRQ_CLR) begin
      rdata_next = 32'h0;
    end else if (s_axi_araddr == `UEFC_OFF_IRQ_EN) begin
      rdata_next = {11'h0, irq_en_reg};
    end else if (s_axi_araddr == `UEFC_OFF_FIFO_ADDR) begin
      rdata_next = {20'h0, fifo_ep_reg, 2'h0, fifo_addr_reg};
    end else if (s_axi_araddr == `UEFC_OFF_FIFO_DATA) begin
      if (fifo_ep_reg < 4'd10)
        rdata_next = {24'h0, fifo_mem[fifo_index(fifo_ep_reg,
                                                 fifo_addr_reg)]};
    end else if (s_axi_araddr == `UEFC_OFF_PAIR) begin
      rdata_next = {22'h0, pair_reg};
    end else begin
      rresp_next = `UEFC_RESP_SLVERR;
    end
    // a debugger read sees no fifo contents
    if (dbg_s2_reg && s_axi_araddr == `UEFC_OFF_FIFO_DATA)
      rdata_next = 32'h0;
  end

  assign s_axi_arready = (rd_state_reg == UEFC_RD_IDLE);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_reg <= UEFC_RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= `UEFC_RESP_OKAY;
    end else begin
      case (rd_state_reg)
        UEFC_RD_IDLE: begin
          if (rd_fire) begin
            rd_state_reg <= UEFC_RD_RESP;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
          end
        end
        UEFC_RD_RESP: begin
          if (s_axi_rready)
            rd_state_reg <= UEFC_RD_IDLE;
        end
        default: rd_state_reg <= UEFC_RD_IDLE;
      endcase
    end
  end

  assign s_axi_rvalid = (rd_state_reg == UEFC_RD_RESP);
  assign mcu_clock_prescale_field = prescale_reg;
  assign in_fifo_busy = in_busy_reg;
  assign out_fifo_busy = out_busy_reg;
  assign in_toggle = toggle_reg;

  // checks on the engine's own state; firmware duties live in the bench
  AST_BUS_RESET_IRQ: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ev_pulse[0] && irq_en_reg[0]) |=> usb_irq)
    else $error("bus reset did not raise interrupt");
  AST_WAKE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (|(stat_reg & irq_en_reg) && idle_s2_reg) |-> mcu_wake)
    else $error("usb interrupt did not wake idle mcu");
  AST_WAKE_ANY_EVENT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (|(ev_pulse & irq_en_reg) && !wr_fire) |=>
    (mcu_wake || !idle_s2_reg))
    else $error("enabled usb event did not wake idle mcu");
  AST_EVENT_STATUS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ev_pulse != 21'h0) |=>
    ((stat_reg & $past(ev_pulse)) == $past(ev_pulse)))
    else $error("usb event not latched in status");
  AST_BUSRST_KEEPS_EN: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ev_pulse[0] && !wr_fire) |=> $stable(ep_en_reg))
    else $error("bus reset changed registers");
  AST_BUSRST_KEEPS_REGS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ev_pulse[0] && !wr_fire) |=>
    $stable({prescale_reg, irq_en_reg, pair_reg, in_busy_reg}))
    else $error("bus reset changed control registers");
  AST_TOGGLE_ONLY_SENT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ev_pulse[10:1] == 10'h0 && $stable(ep_en_reg)) |=>
    $stable(toggle_reg))
    else $error("toggle moved without a sent packet");
  AST_TOGGLE_FLIP: assert property (
    @(posedge clk) disable iff (!reset_n)
    (|(ev_pulse[10:1] & ep_en_reg)) |=> (toggle_reg != $past(toggle_reg)))
    else $error("sent packet did not advance toggle");
  AST_TOGGLE_CLR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ep_en_reg == 10'h0) |=> (toggle_reg == 10'h0))
    else $error("disabled endpoint kept its toggle");
  AST_TOGGLE_ONLY_ENABLED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (toggle_reg & ~$past(ep_en_reg)) == 10'h0)
    else $error("toggle set on an endpoint that was disabled");
  AST_IN_BUSY_KEPT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!(wr_fire && awaddr_reg == `UEFC_OFF_IN_BUSY)) |=>
    $stable(in_busy_reg))
    else $error("in busy changed without firmware write");
  AST_IN_BUSY_NO_HW_CLEAR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (|(ev_pulse[10:1] & in_busy_reg) && !wr_fire) |=>
    ((in_busy_reg & $past(in_busy_reg)) == $past(in_busy_reg)))
    else $error("engine cleared in busy after a send");
  AST_OUT_BUSY_KEPT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!(wr_fire && awaddr_reg == `UEFC_OFF_OUT_BUSY)) |=>
    ((out_busy_reg & $past(out_busy_reg)) == $past(out_busy_reg)))
    else $error("engine cleared out busy on its own");
  AST_DBG_NO_FIFO: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_fire && dbg_s2_reg && s_axi_araddr == `UEFC_OFF_FIFO_DATA) |=>
    (s_axi_rdata == 32'h0))
    else $error("debugger saw fifo contents");
  AST_STAT_SET_WINS: assert property (
    @(posedge clk) disable iff (!reset_n)
    ev_pulse[0] |=> stat_reg[0])
    else $error("bus reset status lost");
endmodule // uefc_top
`default_nettype wire

/* File: tb/test_usb_endpoint_fifo_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uefc_defs.svh"
module test_usb_endpoint_fifo_control;
  import uefc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, mcu_idle = 0, dbg_access = 0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, usb_bus_reset, usb_irq, mcu_wake;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] mcu_clock_prescale_field, ps;
  uefc_word_t s_axi_rdata, rd_data, d;
  uefc_ep_t usb_in_sent, usb_out_rcvd, in_fifo_busy, out_fifo_busy, in_toggle;
  int bad_count = 0, checks_done = 0, cyc = 0, e;
  always #5 clk = ~clk;
  uefc_top uut (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .usb_bus_reset(usb_bus_reset),
    .usb_in_sent(usb_in_sent), .usb_out_rcvd(usb_out_rcvd),
    .mcu_idle(mcu_idle), .dbg_access(dbg_access),
    .mcu_clock_prescale_field(mcu_clock_prescale_field),
    .in_fifo_busy(in_fifo_busy), .out_fifo_busy(out_fifo_busy),
    .in_toggle(in_toggle), .usb_irq(usb_irq), .mcu_wake(mcu_wake)
  );
  uefc_host_model host (
    .clk(clk), .usb_bus_reset(usb_bus_reset), .usb_in_sent(usb_in_sent),
    .usb_out_rcvd(usb_out_rcvd)
  );
  function automatic uefc_ep_t flip(uefc_ep_t v, int ep);
    return v ^ (10'h1 << ep);
  endfunction
  task automatic chk(input string what, input uefc_word_t seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input uefc_addr_t a, input uefc_word_t v);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end while (!b_ok);
    s_axi_bready <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input uefc_addr_t a);
    logic ar_ok, r_ok;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_ok = s_axi_arvalid & s_axi_arready;
      r_ok = s_axi_rvalid;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end while (!r_ok);
    s_axi_rready <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rchk(input string what, input uefc_addr_t a, uefc_word_t x);
    rd(a);
    chk(what, rd_data, x);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(19));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("reset toggle", in_toggle, 0);
    chk("reset prescale", mcu_clock_prescale_field, 0);
    ps = 3'($urandom_range(7, 1));
    e = $urandom_range(9, 0);
    wr(`UEFC_OFF_CTRL, 32'(ps));
    wr(`UEFC_OFF_IRQ_EN, 32'h1);
    wr(`UEFC_OFF_EP_EN, 32'h1 << e);
    wr(`UEFC_OFF_IN_BUSY, 32'h1 << e);
    mcu_idle <= 1'b1;
    host.pulse(0, 0, $urandom_range(5, 0));
    chk("bus reset irq", usb_irq, 1);
    chk("wake", mcu_wake, 1);
    rchk("status", `UEFC_OFF_IRQ_STAT, 32'h1);
    chk("prescale kept", mcu_clock_prescale_field, 32'(ps));
    chk("busy kept", in_fifo_busy, 32'h1 << e);
    rchk("ep enable kept", `UEFC_OFF_EP_EN, 32'h1 << e);
    wr(`UEFC_OFF_IRQ_CLR, 32'h1fffff);
    chk("irq cleared", usb_irq, 0);
    $display("bus reset test done");
    host.pulse(1, e, $urandom_range(5, 0));
    chk("toggle", in_toggle, flip(10'h0, e));
    chk("in busy stays", in_fifo_busy, 32'h1 << e);
    wr(`UEFC_OFF_TOGGLE, 32'h0);
    chk("toggle write resp", resp, `UEFC_RESP_SLVERR);
    chk("toggle unchanged", in_toggle, flip(10'h0, e));
    host.pulse(1, e, 0);
    host.pulse(1, e, 0);
    chk("toggle after double send", in_toggle,
        flip(flip(flip(10'h0, e), e), e));
    wr(`UEFC_OFF_IRQ_EN, 32'h2 << e);
    chk("in irq", usb_irq, 1);
    chk("in wake", mcu_wake, 1);
    mcu_idle <= 1'b0;
    repeat (3) @(negedge clk);
    chk("no wake when running", mcu_wake, 0);
    wr(`UEFC_OFF_IRQ_EN, 32'h0);
    chk("masked irq", usb_irq, 0);
    wr(`UEFC_OFF_IN_BUSY, 32'h0);
    chk("in busy cleared", in_fifo_busy, 0);
    wr(`UEFC_OFF_EP_EN, 32'h0);
    wr(`UEFC_OFF_EP_EN, 32'h1 << e);
    chk("toggle after re-enable", in_toggle, 0);
    $display("toggle test done");
    wr(`UEFC_OFF_IRQ_CLR, 32'h1fffff);
    host.pulse(2, e, 0);
    chk("out busy", out_fifo_busy, 32'h1 << e);
    rchk("out status", `UEFC_OFF_IRQ_STAT, 32'h800 << e);
    wr(`UEFC_OFF_OUT_BUSY, 32'h0);
    chk("out busy cleared", out_fifo_busy, 0);
    $display("out test done");
    d = {1'b0, 31'($urandom)};
    wr(`UEFC_OFF_FIFO_ADDR, 32'(e) << 8);
    wr(`UEFC_OFF_FIFO_DATA, d);
    wr(`UEFC_OFF_FIFO_ADDR, 32'(e) << 8);
    dbg_access <= 1'b1;
    // the debugger flag passes two flops before the engine sees it
    repeat (2) @(negedge clk);
    rchk("debugger fifo read", `UEFC_OFF_FIFO_DATA, 32'h0);
    dbg_access <= 1'b0;
    wr(`UEFC_OFF_FIFO_ADDR, 32'(e) << 8);
    // each fifo entry is one byte, returned in the low bits of the word
    rchk("firmware fifo read", `UEFC_OFF_FIFO_DATA, {24'h0, d[7:0]});
    rchk("unmapped read", 8'h40, 32'h0);
    chk("unmapped resp", resp, `UEFC_RESP_SLVERR);
    $display("fifo test done");
    give_verdict();
  end
endmodule // test_usb_endpoint_fifo_control
`default_nettype wire

/* File: tb/uefc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module uefc_host_model (
  input wire logic clk,
  output logic usb_bus_reset,
  output logic [9:0] usb_in_sent,
  output logic [9:0] usb_out_rcvd
);
  initial begin
    usb_bus_reset = 1'b0;
    usb_in_sent = 10'h0;
    usb_out_rcvd = 10'h0;
  end
  // events last two cycles so the engine's synchroniser sees each one
  task automatic pulse(input int kind, input int ep, input int gap);
    @(posedge clk);
    if (kind == 0) usb_bus_reset <= 1'b1;
    else if (kind == 1) usb_in_sent[ep] <= 1'b1;
    else usb_out_rcvd[ep] <= 1'b1;
    repeat (2) @(posedge clk);
    usb_bus_reset <= 1'b0;
    usb_in_sent <= 10'h0;
    usb_out_rcvd <= 10'h0;
    repeat (gap + 4) @(posedge clk);
    @(negedge clk);
  endtask
endmodule // uefc_host_model
`default_nettype wire
